// >>> inc/cfg_decode_map.svh
`ifndef CFG_DECODE_MAP_SVH
`define CFG_DECODE_MAP_SVH

// word geometry and blank value
`define CFG_WORD_W          14
`define CFG_WORD_BLANK      14'h3FFF

// unimplemented positions, forced to one on capture
`define SUP_UNIMPL_MASK     14'h0510
`define MEM_UNIMPL_MASK     14'h1FFC
`define GRD_UNIMPL_MASK     14'h3FFC

// supervisor word fields
`define SUP_DEBUG_BIT       13
`define SUP_STACK_RST_BIT   12
`define SUP_REMAP_1WAY_BIT  11
`define SUP_BOR_LEVEL_BIT   9
`define SUP_BOR_MODE_HI     7
`define SUP_BOR_MODE_LO     6
`define SUP_LPBOR_BIT       5
`define SUP_WDT_HI          3
`define SUP_WDT_LO          2
`define SUP_POWERUP_TIMER_BIT        1
`define SUP_RESET_PIN_BIT   0

// memory word fields
`define MEM_LVP_BIT         13
`define MEM_SWG_HI          1
`define MEM_SWG_LO          0

// code guard word fields
`define GRD_EEPROM_BIT      1
`define GRD_PROGRAM_BIT     0

// brown-out mode codes
`define BOR_MODE_ON         2'h3
`define BOR_MODE_SLEEP      2'h2
`define BOR_MODE_SOFT       2'h1
`define BOR_MODE_OFF        2'h0

// watchdog forced-on code
`define WDT_FORCED_ON       2'h3

// self-write guard codes and limits
`define SWG_OFF             2'h3
`define SWG_BOOT            2'h2
`define SWG_HALF            2'h1
`define SWG_ALL             2'h0
`define SWG_BOOT_LAST       11'h1FF
`define SWG_HALF_LAST       11'h3FF
`define SWG_ALL_LAST        11'h7FF

// register map (byte addresses)
`define REG_SUP_OFF         8'h00
`define REG_MEM_OFF         8'h04
`define REG_GRD_OFF         8'h08
`define REG_CTRL_OFF        8'h0C
`define REG_STAT_OFF        8'h10

// control and status fields
`define CTRL_SOFT_BOR_BIT   0
`define CTRL_REMAP_BIT      1
`define STAT_BOR_ACT_BIT    0
`define STAT_REMAP_SPENT    1
`define STAT_LOADED_BIT     2

`endif

// >>> inc/cfg_decode_pkg.sv
`include "cfg_decode_map.svh"

package cfg_decode_pkg;

	typedef struct packed {
		logic                     loaded;
		logic [`CFG_WORD_W-1:0]   sup;
		logic [`CFG_WORD_W-1:0]   mem;
		logic [`CFG_WORD_W-1:0]   grd;
		logic                     soft_bor;
		logic                     remap_flag;
		logic                     remap_spent;
		logic                     pready;
		logic                     pslverr;
		logic [31:0]              prdata;
		logic                     debug_owned;
		logic                     stack_rst;
		logic                     bor_level_low;
		logic                     bor_active;
		logic                     lpbor_on;
		logic                     wdt_on;
		logic                     powerup_timer_on;
		logic                     reset_pin_external_master_reset;
		logic                     lvp_allowed;
		logic                     lvp_refused;
		logic                     lvp_accepted;
		logic                     sw_grant;
		logic                     sw_blocked;
		logic                     pm_wgrant;
		logic                     ee_wgrant;
		logic                     ee_guard;
		logic                     pm_guard;
		logic [`CFG_WORD_W-1:0]   pm_rdata;
		logic [7:0]               ee_rdata;
	} cfg_state_t;

endpackage

// >>> logic/supervisor_memory_config_decode.sv
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "cfg_decode_map.svh"

// Functional notes
// - debug field clear gives both debug pins to debugger; set leaves them ordinary io
// - stack fault reset enable set: overflow/underflow resets device; clear: no reset
// - one-way option: remap lock flag cycles once then stays locked; else toggles freely
// - brown-out level select: clear picks high trip level, set picks low level
// - brown-out mode 11 always on ignoring software enable; 00 brown-out off
// - brown-out mode 10 on while running, off in sleep, software enable ignored
// - brown-out mode 01 follows software brown-out enable bit
// - low-power brown-out monitor on when its bit is clear, off when set
// - watchdog field 11 forces the watchdog permanently on
// - power-up timer on when its bit is clear, off when set
// - low-voltage programming enabled: shared pin is always external master reset
// - otherwise shared pin is master reset when pin enable set, port when clear
// - low-voltage bit set allows low-voltage entry; clear needs high voltage entry
// - refuse clearing low-voltage bit while programming was entered by low voltage
// - self-write guard 11: no address protected
// - self-write guard 10: 0000h-01FFh blocked, rest through 07FFh writable
// - self-write guard 01: 0000h-03FFh blocked, 0400h upward writable
// - self-write guard 00: all addresses through 07FFh blocked
// - self-write guard gates only own software writes, never serial port writes
// - eeprom external guard active when its bit is clear, inactive when set
// - program external guard active when its bit is clear, inactive when set
// - unimplemented word positions read back as one
// - eeprom guard active: external eeprom reads give zero, writes inhibited
// - program guard active: external program reads give zero, writes inhibited
module supervisor_memory_config_decode
	import cfg_decode_pkg::*;
#(
	parameter int ADDR_W = 11
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   clk_en,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic [31:0]                 prdata,
	input  wire logic [`CFG_WORD_W-1:0] nvm_supervisor_word,
	input  wire logic [`CFG_WORD_W-1:0] nvm_memory_word,
	input  wire logic [`CFG_WORD_W-1:0] nvm_code_guard_word,
	input  wire logic                   sleep_mode,
	input  wire logic                   stack_overflow,
	input  wire logic                   stack_underflow,
	input  wire logic                   remap_unlock_ok,
	input  wire logic                   prog_entered_lvp,
	input  wire logic                   lvp_clear_req,
	input  wire logic                   self_write_req,
	input  wire logic [ADDR_W-1:0]      self_write_addr,
	input  wire logic                   serial_pm_write_req,
	input  wire logic                   serial_ee_write_req,
	input  wire logic [`CFG_WORD_W-1:0] serial_pm_rdata_in,
	input  wire logic [7:0]             serial_ee_rdata_in,
	output logic                        debug_pins_owned,
	output logic                        stack_fault_reset,
	output logic                        remap_locked_flag,
	output logic                        brownout_trip_level,
	output logic                        brownout_reset_active,
	output logic                        low_power_brownout_monitor,
	output logic                        watchdog_forced_on,
	output logic                        powerup_timer,
	output logic                        external_master_reset,
	output logic                        lvp_entry_allowed,
	output logic                        lvp_clear_refused,
	output logic                        lvp_clear_accepted,
	output logic                        self_write_grant,
	output logic                        self_write_blocked,
	output logic                        serial_pm_write_grant,
	output logic                        serial_ee_write_grant,
	output logic                        eeprom_read_guard_active,
	output logic                        program_read_guard_active,
	output logic [`CFG_WORD_W-1:0]      serial_pm_rdata,
	output logic [7:0]                  serial_ee_rdata
);

	cfg_state_t state_q;
	cfg_state_t state_d;

	logic             apb_done;
	logic             apb_wr;
	logic [1:0]       bor_mode;
	logic [1:0]       swg_mode;
	logic [ADDR_W-1:0] swg_last;
	logic             swg_hit;
	logic             lvp_on;
	logic             remap_wr_val;

	assign apb_done     = psel && penable && state_q.pready;
	assign apb_wr       = apb_done && pwrite;
	assign bor_mode     = state_q.sup[`SUP_BOR_MODE_HI:`SUP_BOR_MODE_LO];
	assign swg_mode     = state_q.mem[`MEM_SWG_HI:`MEM_SWG_LO];
	assign lvp_on       = state_q.mem[`MEM_LVP_BIT];
	assign remap_wr_val = pwdata[`CTRL_REMAP_BIT];

	// limit of the protected range; the top code never matches since swg_hit is masked
	always_comb begin
		case (swg_mode)
			`SWG_BOOT: swg_last = ADDR_W'(`SWG_BOOT_LAST);
			`SWG_HALF: swg_last = ADDR_W'(`SWG_HALF_LAST);
			`SWG_ALL:  swg_last = ADDR_W'(`SWG_ALL_LAST);
			default:   swg_last = '0;
		endcase
	end

	assign swg_hit = (swg_mode != `SWG_OFF) && (self_write_addr <= swg_last);

	always_comb begin
		state_d = state_q;
		if (clk_en) begin
			// capture happens once; the words then stay put until the next reset
			if (!state_q.loaded) begin
				state_d.loaded = 1'b1;
				state_d.sup    = nvm_supervisor_word | `SUP_UNIMPL_MASK;
				state_d.mem    = nvm_memory_word | `MEM_UNIMPL_MASK;
				state_d.grd    = nvm_code_guard_word | `GRD_UNIMPL_MASK;
			end

			// one wait state so read data can come from a flop
			state_d.pready  = psel && penable && !state_q.pready;
			state_d.pslverr = 1'b0;
			state_d.prdata  = '0;
			if (psel && penable && !state_q.pready && !pwrite) begin
				case (paddr)
					`REG_SUP_OFF:  state_d.prdata = 32'(state_q.sup);
					`REG_MEM_OFF:  state_d.prdata = 32'(state_q.mem);
					`REG_GRD_OFF:  state_d.prdata = 32'(state_q.grd);
					`REG_CTRL_OFF: begin
						state_d.prdata[`CTRL_SOFT_BOR_BIT] = state_q.soft_bor;
						state_d.prdata[`CTRL_REMAP_BIT]    = state_q.remap_flag;
					end
					`REG_STAT_OFF: begin
						state_d.prdata[`STAT_BOR_ACT_BIT] = state_q.bor_active;
						state_d.prdata[`STAT_REMAP_SPENT] = state_q.remap_spent;
						state_d.prdata[`STAT_LOADED_BIT]  = state_q.loaded;
					end
					default:       state_d.pslverr = 1'b1;
				endcase
			end else if (psel && penable && !state_q.pready) begin
				state_d.pslverr = (paddr != `REG_CTRL_OFF);
			end

			if (apb_wr && paddr == `REG_CTRL_OFF) begin
				state_d.soft_bor = pwdata[`CTRL_SOFT_BOR_BIT];
				// lock flag moves only after the unlock sequence seen by the core
				if (remap_unlock_ok && !state_q.remap_spent) begin
					state_d.remap_flag = remap_wr_val;
					if (state_q.sup[`SUP_REMAP_1WAY_BIT] && remap_wr_val && !state_q.remap_flag) begin
						state_d.remap_spent = 1'b1;
					end
				end
			end

			state_d.debug_owned   = !state_q.sup[`SUP_DEBUG_BIT];
			state_d.stack_rst     = state_q.sup[`SUP_STACK_RST_BIT]
				&& (stack_overflow || stack_underflow);
			state_d.bor_level_low = state_q.sup[`SUP_BOR_LEVEL_BIT];
			case (bor_mode)
				`BOR_MODE_ON:    state_d.bor_active = 1'b1;
				`BOR_MODE_SLEEP: state_d.bor_active = !sleep_mode;
				`BOR_MODE_SOFT:  state_d.bor_active = state_q.soft_bor;
				default:         state_d.bor_active = 1'b0;
			endcase
			state_d.lpbor_on       = !state_q.sup[`SUP_LPBOR_BIT];
			state_d.wdt_on         = state_q.sup[`SUP_WDT_HI:`SUP_WDT_LO] == `WDT_FORCED_ON;
			state_d.powerup_timer_on        = !state_q.sup[`SUP_POWERUP_TIMER_BIT];
			state_d.reset_pin_external_master_reset = lvp_on || state_q.sup[`SUP_RESET_PIN_BIT];
			state_d.lvp_allowed    = lvp_on;
			state_d.lvp_refused    = lvp_clear_req && prog_entered_lvp;
			state_d.lvp_accepted   = lvp_clear_req && !prog_entered_lvp;
			state_d.sw_grant       = self_write_req && !swg_hit;
			state_d.sw_blocked     = self_write_req && swg_hit;

			state_d.ee_guard  = !state_q.grd[`GRD_EEPROM_BIT];
			state_d.pm_guard  = !state_q.grd[`GRD_PROGRAM_BIT];
			// serial port writes ignore the self-write guard, only code protection applies
			state_d.pm_wgrant = serial_pm_write_req && state_q.grd[`GRD_PROGRAM_BIT];
			state_d.ee_wgrant = serial_ee_write_req && state_q.grd[`GRD_EEPROM_BIT];
			state_d.pm_rdata  = state_q.grd[`GRD_PROGRAM_BIT] ? serial_pm_rdata_in : '0;
			state_d.ee_rdata  = state_q.grd[`GRD_EEPROM_BIT] ? serial_ee_rdata_in : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q         <= '0;
			state_q.sup     <= `CFG_WORD_BLANK;
			state_q.mem     <= `CFG_WORD_BLANK;
			state_q.grd     <= `CFG_WORD_BLANK;
			state_q.lpbor_on <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign pready                     = state_q.pready;
	assign pslverr                    = state_q.pslverr;
	assign prdata                     = state_q.prdata;
	assign debug_pins_owned           = state_q.debug_owned;
	assign stack_fault_reset          = state_q.stack_rst;
	assign remap_locked_flag          = state_q.remap_flag;
	assign brownout_trip_level        = state_q.bor_level_low;
	assign brownout_reset_active      = state_q.bor_active;
	assign low_power_brownout_monitor = state_q.lpbor_on;
	assign watchdog_forced_on         = state_q.wdt_on;
	assign powerup_timer              = state_q.powerup_timer_on;
	assign external_master_reset      = state_q.reset_pin_external_master_reset;
	assign lvp_entry_allowed          = state_q.lvp_allowed;
	assign lvp_clear_refused          = state_q.lvp_refused;
	assign lvp_clear_accepted         = state_q.lvp_accepted;
	assign self_write_grant           = state_q.sw_grant;
	assign self_write_blocked         = state_q.sw_blocked;
	assign serial_pm_write_grant      = state_q.pm_wgrant;
	assign serial_ee_write_grant      = state_q.ee_wgrant;
	assign eeprom_read_guard_active   = state_q.ee_guard;
	assign program_read_guard_active  = state_q.pm_guard;
	assign serial_pm_rdata            = state_q.pm_rdata;
	assign serial_ee_rdata            = state_q.ee_rdata;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	debug_pins_a: assert property (clk_en && state_q.loaded |=>
		debug_pins_owned == !$past(state_q.sup[`SUP_DEBUG_BIT]))
		else $error("debug pin ownership wrong");

	stack_reset_a: assert property (clk_en && (stack_overflow || stack_underflow) |=>
		stack_fault_reset == $past(state_q.sup[`SUP_STACK_RST_BIT]))
		else $error("stack fault reset wrong");

	remap_spent_a: assert property (state_q.remap_spent |=> remap_locked_flag && state_q.remap_spent)
		else $error("spent remap lock moved");

	bor_forced_a: assert property (clk_en && bor_mode == `BOR_MODE_ON |=> brownout_reset_active)
		else $error("brown-out not forced on");

	bor_sleep_a: assert property (clk_en && bor_mode == `BOR_MODE_SLEEP |=>
		brownout_reset_active == !$past(sleep_mode))
		else $error("brown-out sleep mode wrong");

	bor_soft_a: assert property (clk_en && bor_mode == `BOR_MODE_SOFT |=>
		brownout_reset_active == $past(state_q.soft_bor))
		else $error("brown-out soft mode wrong");

	bor_off_a: assert property (clk_en && bor_mode == `BOR_MODE_OFF |=> !brownout_reset_active)
		else $error("brown-out not off");

	reset_pin_a: assert property (clk_en && lvp_on |=> external_master_reset)
		else $error("shared pin not master reset");

	lvp_refuse_a: assert property (clk_en && lvp_clear_req && prog_entered_lvp |=>
		lvp_clear_refused && !lvp_clear_accepted)
		else $error("low-voltage clear not refused");

	self_write_all_a: assert property (clk_en && self_write_req && swg_mode == `SWG_ALL |=>
		self_write_blocked && !self_write_grant)
		else $error("self-write not blocked");

	self_write_half_a: assert property (clk_en && self_write_req && swg_mode == `SWG_HALF
		&& self_write_addr > ADDR_W'(`SWG_HALF_LAST) |=> self_write_grant)
		else $error("upper half self-write blocked");

	ee_guard_read_a: assert property (clk_en && !state_q.grd[`GRD_EEPROM_BIT] |=>
		serial_ee_rdata == '0 && !serial_ee_write_grant)
		else $error("guarded eeprom leaked");

	words_hold_a: assert property (state_q.loaded |=> $stable(state_q.sup) && $stable(state_q.grd))
		else $error("configuration words changed");

	apb_answer_a: assert property (psel && penable && !pready && clk_en |=> pready ##1 !pready)
		else $error("bus answer timing wrong");

	bor_sleep_c: cover property (bor_mode == `BOR_MODE_SLEEP && sleep_mode ##1 !brownout_reset_active);
	lvp_refuse_c: cover property (lvp_clear_refused);
	remap_spent_c: cover property ($rose(state_q.remap_spent));
	boot_block_c: cover property (swg_mode == `SWG_BOOT && self_write_blocked);

endmodule

// >>> verif/supervisor_memory_config_decode_bench.sv
`timescale 1ns/10ps
`include "cfg_decode_map.svh"

module supervisor_memory_config_decode_bench import cfg_decode_pkg::*;;
	logic                   pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic [`CFG_WORD_W-1:0] nvm_supervisor_word, nvm_memory_word, nvm_code_guard_word;
	logic                   sleep_mode, stack_overflow, stack_underflow, remap_unlock_ok, prog_entered_lvp;
	logic                   lvp_clear_req, self_write_req, serial_pm_write_req, serial_ee_write_req, er;
	logic [10:0]            self_write_addr;
	logic [`CFG_WORD_W-1:0] serial_pm_rdata_in, serial_pm_rdata;
	logic [7:0]             serial_ee_rdata_in, serial_ee_rdata;
	logic                   debug_pins_owned, stack_fault_reset, remap_locked_flag, brownout_trip_level;
	logic                   brownout_reset_active, low_power_brownout_monitor, watchdog_forced_on, powerup_timer;
	logic                   external_master_reset, lvp_entry_allowed, lvp_clear_refused, lvp_clear_accepted;
	logic                   self_write_grant, self_write_blocked, serial_pm_write_grant, serial_ee_write_grant;
	logic                   eeprom_read_guard_active, program_read_guard_active;
	int                     n_fail, checks;

	supervisor_memory_config_decode u_supervisor_memory_config_decode (
		.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
		.nvm_supervisor_word, .nvm_memory_word, .nvm_code_guard_word, .sleep_mode, .stack_overflow,
		.stack_underflow, .remap_unlock_ok, .prog_entered_lvp, .lvp_clear_req, .self_write_req,
		.self_write_addr, .serial_pm_write_req, .serial_ee_write_req, .serial_pm_rdata_in,
		.serial_ee_rdata_in, .debug_pins_owned, .stack_fault_reset, .remap_locked_flag,
		.brownout_trip_level, .brownout_reset_active, .low_power_brownout_monitor, .watchdog_forced_on,
		.powerup_timer, .external_master_reset, .lvp_entry_allowed, .lvp_clear_refused,
		.lvp_clear_accepted, .self_write_grant, .self_write_blocked, .serial_pm_write_grant,
		.serial_ee_write_grant, .eeprom_read_guard_active, .program_read_guard_active,
		.serial_pm_rdata, .serial_ee_rdata
	);

	always #2.5 pclk = ~pclk;

	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// words are sampled only at reset release, so each configuration needs its own reset
	task automatic cfg(input logic [13:0] s, input logic [13:0] m, input logic [13:0] g);
		@(posedge pclk);
		presetn <= 1'b0;
		nvm_supervisor_word <= s;
		nvm_memory_word <= m;
		nvm_code_guard_word <= g;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		tick(3);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(n < 50, 1, "apb answer");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read data");
		chk(er, 0, "read error");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk(er, 0, "write error");
		tick(2);
	endtask

	// bits: stack overflow, stack underflow, serial pm, serial ee, lvp clear
	task automatic kick(input logic [4:0] m);
		@(posedge pclk);
		{lvp_clear_req, serial_ee_write_req, serial_pm_write_req, stack_underflow, stack_overflow} <= m;
		@(posedge pclk);
		{lvp_clear_req, serial_ee_write_req, serial_pm_write_req, stack_underflow, stack_overflow} <= 5'h00;
		#1;
	endtask

	task automatic sw(input logic [10:0] a, input logic g, input logic b);
		@(posedge pclk);
		self_write_req <= 1'b1;
		self_write_addr <= a;
		@(posedge pclk);
		self_write_req <= 1'b0;
		#1;
		chk(self_write_grant, g, "self write grant");
		chk(self_write_blocked, b, "self write block");
	endtask

	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{sleep_mode, stack_overflow, stack_underflow, prog_entered_lvp, lvp_clear_req} = '0;
		{self_write_req, self_write_addr, serial_pm_write_req, serial_ee_write_req} = '0;
		{nvm_supervisor_word, nvm_memory_word, nvm_code_guard_word} = '0;
		clk_en = 1'b1;
		remap_unlock_ok = 1'b1;
		serial_pm_rdata_in = 14'h2A5A;
		serial_ee_rdata_in = 8'hC3;
		n_fail = 0;
		checks = 0;

		// all programmable bits cleared: every guard on, brown-out and stack fault reset off
		cfg(14'h0000, 14'h0000, 14'h0000);
		chk(debug_pins_owned, 1, "debug owner");
		chk(brownout_trip_level, 0, "trip level");
		chk(brownout_reset_active, 0, "bor off");
		chk(low_power_brownout_monitor, 1, "lpbor on");
		chk(watchdog_forced_on, 0, "wdt");
		chk(powerup_timer, 1, "powerup_timer on");
		chk(external_master_reset, 0, "port pin");
		chk(lvp_entry_allowed, 0, "lvp entry");
		chk(eeprom_read_guard_active, 1, "ee guard");
		chk(program_read_guard_active, 1, "pm guard");
		chk(serial_ee_rdata, 0, "ee read zero");
		chk(serial_pm_rdata, 0, "pm read zero");
		kick(5'h0C);
		chk(serial_ee_write_grant, 0, "ee write");
		chk(serial_pm_write_grant, 0, "pm write");
		kick(5'h01);
		chk(stack_fault_reset, 0, "no stack reset");
		sw(11'h7FF, 1'b0, 1'b1);
		sw(11'h000, 1'b0, 1'b1);
		rdchk(8'h00, 32'h0510);
		rdchk(8'h04, 32'h1FFC);
		rdchk(8'h08, 32'h3FFC);
		rdchk(8'h10, 32'h4);
		nvm_supervisor_word <= 14'h3FFF;
		rdchk(8'h00, 32'h0510);
		apb(1'b1, 8'h00, 32'hFFFF);
		chk(er, 1, "write to word");
		apb(1'b0, 8'h14, 32'h0);
		chk(er, 1, "unmapped error");
		chk(rd, 0, "unmapped data");
		$display("test all_protected done");

		// blank words: every guard released
		cfg(14'h3FFF, 14'h3FFF, 14'h3FFF);
		chk(debug_pins_owned, 0, "pins io");
		chk(brownout_trip_level, 1, "low trip");
		chk(low_power_brownout_monitor, 0, "lpbor off");
		chk(watchdog_forced_on, 1, "wdt on");
		chk(powerup_timer, 0, "powerup_timer off");
		chk(external_master_reset, 1, "reset pin");
		chk(lvp_entry_allowed, 1, "lvp entry");
		chk(eeprom_read_guard_active, 0, "ee open");
		chk(program_read_guard_active, 0, "pm open");
		chk(serial_ee_rdata, 8'hC3, "ee read");
		chk(serial_pm_rdata, 14'h2A5A, "pm read");
		@(posedge pclk) sleep_mode <= 1'b1;
		tick(2);
		chk(brownout_reset_active, 1, "bor always");
		kick(5'h0E);
		chk(stack_fault_reset, 1, "stack reset");
		chk(serial_pm_write_grant, 1, "pm write");
		chk(serial_ee_write_grant, 1, "ee write");
		sw(11'h000, 1'b1, 1'b0);
		sw(11'h7FF, 1'b1, 1'b0);
		rdchk(8'h00, 32'h3FFF);
		$display("test blank_words done");

		// sleep gated brown-out, boot guard, lvp pin
		cfg(14'h0080, 14'h2002, 14'h3FFF);
		chk(brownout_reset_active, 0, "bor asleep");
		@(posedge pclk) sleep_mode <= 1'b0;
		tick(2);
		chk(brownout_reset_active, 1, "bor awake");
		// clock enable low must freeze the decoded level even though sleep changes
		@(posedge pclk) clk_en <= 1'b0;
		@(posedge pclk) sleep_mode <= 1'b1;
		tick(3);
		chk(brownout_reset_active, 1, "bor frozen");
		@(posedge pclk) clk_en <= 1'b1;
		tick(2);
		chk(brownout_reset_active, 0, "bor asleep again");
		chk(external_master_reset, 1, "lvp reset pin");
		sw(11'h1FF, 1'b0, 1'b1);
		sw(11'h200, 1'b1, 1'b0);
		kick(5'h04);
		chk(serial_pm_write_grant, 1, "serial ignores guard");
		@(posedge pclk) prog_entered_lvp <= 1'b1;
		kick(5'h10);
		chk(lvp_clear_refused, 1, "lvp refuse");
		chk(lvp_clear_accepted, 0, "lvp no accept");
		@(posedge pclk) prog_entered_lvp <= 1'b0;
		kick(5'h10);
		chk(lvp_clear_refused, 0, "lvp no refuse");
		chk(lvp_clear_accepted, 1, "lvp accept");
		wr(8'h0C, 32'h2);
		chk(remap_locked_flag, 1, "remap set");
		wr(8'h0C, 32'h0);
		chk(remap_locked_flag, 0, "remap cleared");
		// without the unlock sequence the flag must not move
		@(posedge pclk) remap_unlock_ok <= 1'b0;
		wr(8'h0C, 32'h2);
		chk(remap_locked_flag, 0, "remap needs unlock");
		@(posedge pclk) remap_unlock_ok <= 1'b1;
		$display("test sleep_boot done");

		// software brown-out, half guard, one-way remap lock
		cfg(14'h0841, 14'h0001, 14'h3FFF);
		chk(external_master_reset, 1, "external_master_reset pin");
		chk(brownout_reset_active, 0, "soft off");
		wr(8'h0C, 32'h1);
		chk(brownout_reset_active, 1, "soft on");
		sw(11'h3FF, 1'b0, 1'b1);
		sw(11'h400, 1'b1, 1'b0);
		wr(8'h0C, 32'h3);
		chk(remap_locked_flag, 1, "one way set");
		wr(8'h0C, 32'h1);
		chk(remap_locked_flag, 1, "one way held");
		rdchk(8'h10, 32'h7);
		$display("test soft_half done");
		end_of_test();
	end
endmodule
